// file: hw/mtm_timer.v
// 8-bit modulo timer with apb register access
//
// Chosen here: the address map and the APB slave port.
`include "mtm_timer_map.vh"
module mtm_timer (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        fixed_freq_clock,
   input  wire        external_count_pin,
   output wire        overflow_irq
);
   reg  [7:0]  compare_limit_reg;
   reg  [7:0]  count_reg;
   reg  [1:0]  source_select_reg;
   reg  [3:0]  divide_select_reg;
   reg         counter_halt_reg;
   reg         overflow_irq_enable_reg;
   reg         overflow_flag_reg;
   reg         clear_armed_reg;
   reg  [7:0]  prescale_reg;
   reg  [2:0]  pin_sync_reg;
   reg  [1:0]  fix_sync_reg;
   reg         src_tick;
   reg         div_tick;
   reg  [7:0]  div_mask;
   wire        access;
   wire        wr;
   wire        rd;
   wire        hit_sc;
   wire        hit_clk;
   wire        hit_cnt;
   wire        hit_cmp;
   wire        wr_sc;
   wire        wr_cmp;
   wire        cnt_reset;
   wire        running;
   wire        at_limit;
   wire        overflow_evt;
   wire        pin_rise;
   wire        pin_fall;
   wire        fix_rise;

   assign access  = psel & penable;
   assign wr      = access & pwrite;
   assign rd      = access & ~pwrite;
   assign pready  = 1'b1;
   assign hit_sc  = (paddr == `MTM_OFS_STATUS_CTRL);
   assign hit_clk = (paddr == `MTM_OFS_CLOCK_CFG);
   assign hit_cnt = (paddr == `MTM_OFS_COUNT);
   assign hit_cmp = (paddr == `MTM_OFS_COMPARE);
   assign pslverr = access & ~(hit_sc | hit_clk | hit_cnt | hit_cmp);
   assign wr_sc   = wr & hit_sc;
   assign wr_cmp  = wr & hit_cmp;
   assign cnt_reset = wr_sc & pwdata[`MTM_BIT_CNT_RESET];

   // pin and fixed clock edge detect on synchronised copies
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync_reg <= 3'h0;
         fix_sync_reg <= 2'h0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], external_count_pin};
         fix_sync_reg <= {fix_sync_reg[0], fixed_freq_clock};
      end
   end
   assign pin_rise = pin_sync_reg[1] & ~pin_sync_reg[2];
   assign pin_fall = ~pin_sync_reg[1] & pin_sync_reg[2];
   assign fix_rise = fix_sync_reg[0] & ~fix_sync_reg[1];

   always @* begin
      case (source_select_reg)
         `MTM_SRC_BUS:      src_tick = 1'b1;
         `MTM_SRC_FIXED:    src_tick = fix_rise;
         `MTM_SRC_PIN_FALL: src_tick = pin_fall;
         default:           src_tick = pin_rise;
      endcase
   end

   always @* begin
      if (divide_select_reg > `MTM_DIV_MAX)
         div_mask = 8'hFF;
      else
         div_mask = (8'h01 << divide_select_reg) - 8'h01;
   end

   assign running  = ~counter_halt_reg;
   // zero limit matches at all ones, giving the full wrap
   assign at_limit = (compare_limit_reg == 8'h00) ? (count_reg == 8'hFF) :
                     (count_reg == compare_limit_reg);
   always @* begin
      div_tick = running & src_tick & ((prescale_reg & div_mask) == div_mask);
   end
   assign overflow_evt = div_tick & at_limit & ~wr_cmp & ~cnt_reset;

   // prescaler: source or divide changes keep the count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prescale_reg <= 8'h00;
      else if (wr_cmp | cnt_reset)
         prescale_reg <= 8'h00;
      else if (running & src_tick)
         prescale_reg <= prescale_reg + 8'h01;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= `MTM_RST_COUNT;
      end else if (wr_cmp | cnt_reset) begin
         count_reg <= 8'h00;
      end else if (div_tick) begin
         if (at_limit)
            count_reg <= 8'h00;
         else
            count_reg <= count_reg + 8'h01;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_limit_reg       <= `MTM_RST_COMPARE;
         source_select_reg       <= `MTM_RST_SRC;
         divide_select_reg       <= `MTM_RST_DIV;
         counter_halt_reg        <= `MTM_RST_HALT;
         overflow_irq_enable_reg <= 1'b0;
      end else begin
         if (wr_cmp)
            compare_limit_reg <= pwdata[7:0];
         if (wr & hit_clk) begin
            source_select_reg <= pwdata[`MTM_SRC_MSB:`MTM_SRC_LSB];
            divide_select_reg <= pwdata[`MTM_DIV_MSB:`MTM_DIV_LSB];
         end
         if (wr_sc) begin
            counter_halt_reg        <= pwdata[`MTM_BIT_HALT];
            overflow_irq_enable_reg <= pwdata[`MTM_BIT_IRQ_EN];
         end
      end
   end

   // two-step flag clear; a new overflow disarms and wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_reg <= 1'b0;
         clear_armed_reg   <= 1'b0;
      end else begin
         if (overflow_evt) begin
            overflow_flag_reg <= 1'b1;
            clear_armed_reg   <= 1'b0;
         end else if (wr_cmp | cnt_reset) begin
            overflow_flag_reg <= 1'b0;
            clear_armed_reg   <= 1'b0;
         end else if (wr_sc) begin
            if (clear_armed_reg & ~pwdata[`MTM_BIT_OVF])
               overflow_flag_reg <= 1'b0;
            clear_armed_reg <= 1'b0;
         end else if (rd & hit_sc & overflow_flag_reg) begin
            clear_armed_reg <= 1'b1;
         end
      end
   end

   assign overflow_irq = overflow_flag_reg & overflow_irq_enable_reg;

   always @* begin
      prdata = 32'h00000000;
      if (hit_sc) begin
         prdata[`MTM_BIT_OVF]    = overflow_flag_reg;
         prdata[`MTM_BIT_IRQ_EN] = overflow_irq_enable_reg;
         prdata[`MTM_BIT_HALT]   = counter_halt_reg;
      end else if (hit_clk) begin
         prdata[`MTM_SRC_MSB:`MTM_SRC_LSB] = source_select_reg;
         prdata[`MTM_DIV_MSB:`MTM_DIV_LSB] = divide_select_reg;
      end else if (hit_cnt) begin
         prdata[7:0] = count_reg;
      end else if (hit_cmp) begin
         prdata[7:0] = compare_limit_reg;
      end
   end
endmodule // mtm_timer

// file: hw/mtm_timer_map.vh
// register map, field positions, reset values and encodings of the modulo timer
// Functional notes
// - modulo zero means free-running full wrap
// - modulo write zeroes count, clears overflow
// - modulo register 8-bit rw, resets zero
// - modes stopped, free, modulo; reset stopped
// - running with nonzero modulo is modulo mode
// - reset: stopped, zero, bus clock, divide one
// - clearing halt bit starts the counter
// - four sources: bus, fixed, pin edges
// - source encodings 00 bus to 11 rising
// - source change keeps the count
// - nine divide ratios, 1 to 256
// - divide codes 0-8, others divide 256
// - divide change keeps the count
// - compare values 0 to 255 accepted
// - count up to modulo, then roll zero
// - overflow flag set on modulo-to-zero transition
// - flag clear: read while set, write zero
// - overflow between steps cancels the clear
// - counter reset bit also clears flag
// - counter reset bit write-only, reads zero
// - interrupt when flag and enable set
// - counter register read-only
`ifndef MTM_TIMER_MAP_VH
`define MTM_TIMER_MAP_VH
`define MTM_OFS_STATUS_CTRL  12'h000
`define MTM_OFS_CLOCK_CFG    12'h004
`define MTM_OFS_COUNT        12'h008
`define MTM_OFS_COMPARE      12'h00C
`define MTM_BIT_OVF          7
`define MTM_BIT_IRQ_EN       6
`define MTM_BIT_CNT_RESET    5
`define MTM_BIT_HALT         4
`define MTM_SRC_LSB          4
`define MTM_SRC_MSB          5
`define MTM_DIV_LSB          0
`define MTM_DIV_MSB          3
`define MTM_SRC_BUS          2'h0
`define MTM_SRC_FIXED        2'h1
`define MTM_SRC_PIN_FALL     2'h2
`define MTM_SRC_PIN_RISE     2'h3
`define MTM_DIV_MAX          4'h8
`define MTM_RST_COMPARE      8'h00
`define MTM_RST_COUNT        8'h00
`define MTM_RST_SRC          2'h0
`define MTM_RST_DIV          4'h0
`define MTM_RST_HALT         1'b1
`endif

// file: test/mtm_timer_asserts.sv
// port-level assertions for the modulo timer
module mtm_timer_asserts (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        overflow_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   wire acc = psel & penable;
   wire rd  = acc & ~pwrite;
   wire wr  = acc & pwrite;
   wire st  = paddr == 12'h000;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_err; acc |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0); endproperty
   a_err: assert property (p_err) else $error("bad pslverr");
   property p_rdy; psel |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_trst; rd & st |-> !prdata[5]; endproperty
   a_trst: assert property (p_trst) else $error("reset bit reads one");
   property p_irq; rd & st |-> overflow_irq == (prdata[7] & prdata[6]); endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_hi; rd |-> prdata[31:8] == 24'h000000; endproperty
   a_hi: assert property (p_hi) else $error("upper bits set");
   property p_cfg; rd & paddr == 12'h004 |-> prdata[7:6] == 2'h0; endproperty
   a_cfg: assert property (p_cfg) else $error("config pad bits set");
   property p_cmp; wr & paddr == 12'h00C |=> !overflow_irq; endproperty
   a_cmp: assert property (p_cmp) else $error("flag kept after compare write");
   property p_clr; wr & st & pwdata[5] |=> !overflow_irq; endproperty
   a_clr: assert property (p_clr) else $error("flag kept after count reset");
   property p_rst; $rose(presetn) |-> !overflow_irq [*3]; endproperty
   a_rst: assert property (p_rst) else $error("irq after reset");
   c_cmp: cover property (wr & paddr == 12'h00C);
   c_ovf: cover property (rd & st & prdata[7]);
   c_irq: cover property (overflow_irq);
endmodule // mtm_timer_asserts
bind mtm_timer mtm_timer_asserts i_mtm_timer_asserts (.*);

// file: test/mtm_timer_bench.sv
// self-checking bench for the modulo timer
module mtm_timer_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        fixed_freq_clock = 1'b0, external_count_pin = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdq, d;
   logic        erq = 1'b0;
   wire         pready, pslverr, overflow_irq;
   integer      n_fail = 0, n_tests = 0, s;
   mtm_timer i_mtm_timer (.*);
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         rdq <= prdata;
         erq <= pslverr;
      end
   end
   task stop_test;
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input [31:0] v, input [31:0] e);
      n_tests = n_tests + 1;
      if (v !== e) begin
         n_fail = n_fail + 1;
         $display("ERROR %0t seen %h expected %h", $time, v, e);
      end
   endtask
   task acc(input w, input [11:0] a, input [31:0] dw);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= dw;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
      d = rdq;
   endtask
   task rd(input [11:0] a, input [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(d, e);
   endtask
   task pulse(input integer n);
      repeat (2 * n) begin
         repeat (4) @(posedge pclk);
         fixed_freq_clock   <= ~fixed_freq_clock;
         external_count_pin <= ~external_count_pin;
      end
      repeat (8) @(posedge pclk);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 32'h10);
      rd(12'h004, 32'h00);
      rd(12'h008, 32'h00);
      rd(12'h00C, 32'h00);
      rd(12'h010, 32'h00);
      chk({31'h0, erq}, 32'h1);
      rd(12'h00C, 32'h00);
      chk({31'h0, erq}, 32'h0);
      acc(1'b1, 12'h008, 32'hFF);
      rd(12'h008, 32'h00);
      acc(1'b1, 12'h00C, 32'hA5);
      rd(12'h00C, 32'hA5);
      acc(1'b1, 12'h00C, 32'h03);
      acc(1'b1, 12'h000, 32'h00);
      repeat (20) @(posedge pclk);
      rd(12'h000, 32'h80);
      acc(1'b0, 12'h008, 32'h0);
      chk({31'h0, d <= 32'h3}, 32'h1);
      repeat (8) @(posedge pclk);
      acc(1'b1, 12'h000, 32'h10);
      rd(12'h000, 32'h90);
      acc(1'b1, 12'h000, 32'h10);
      rd(12'h000, 32'h10);
      acc(1'b1, 12'h000, 32'h40);
      repeat (20) @(posedge pclk);
      chk({31'h0, overflow_irq}, 32'h1);
      acc(1'b1, 12'h000, 32'h70);
      rd(12'h000, 32'h50);
      rd(12'h008, 32'h00);
      acc(1'b1, 12'h000, 32'h00);
      repeat (20) @(posedge pclk);
      acc(1'b1, 12'h00C, 32'h00);
      rd(12'h000, 32'h00);
      repeat (300) @(posedge pclk);
      rd(12'h000, 32'h80);
      acc(1'b1, 12'h004, 32'h0F);
      rd(12'h004, 32'h0F);
      acc(1'b1, 12'h00C, 32'h00);
      repeat (200) @(posedge pclk);
      rd(12'h008, 32'h00);
      for (s = 1; s < 4; s = s + 1) begin
         acc(1'b1, 12'h000, 32'h10);
         acc(1'b1, 12'h004, s * 16);
         acc(1'b1, 12'h00C, 32'h00);
         acc(1'b1, 12'h000, 32'h00);
         pulse(3);
         rd(12'h008, 32'h03);
      end
      acc(1'b1, 12'h004, 32'h10);
      pulse(2);
      rd(12'h008, 32'h05);
      acc(1'b1, 12'h004, 32'h11);
      pulse(2);
      rd(12'h008, 32'h06);
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail = n_fail + 1;
      stop_test;
   end
endmodule // mtm_timer_bench
